/* design/msd_status.v */
// Modem control, hook relay, eye quality and carrier detect word space
//
// Behaviour
// - Forced retrain starts at the first baud tick after host sets the bit on a V.22bis link.
// - Carrier flag drops at retrain start, rises at retrain completion.
// - Force bit clears on retrain start and on any data mode write.
// - Hook relay pin is the inverse of the hook relay enable bit.
// - Dial or data mode write sets hook relay enable.
// - Reset clears hook relay enable, relay pin inactive.
// - In V.22 family data modes, eye level above limit sets error flag.
// - Eye limit resets to default; host value applies at baud end.
// - Carrier flag clears when energy falls below the off level.
// - Carrier flag sets when energy rises above the on level.
// - Detect levels reset to defaults; host values apply after baud.
// - Data mode codes are 8, 9, B, 10, 11, 13 and 14 hex.
`timescale 1ns/100ps
`include "msd_defines.vh"
module msd_status (
  // Clock and reset
  input wire clock,
  input wire reset,
  // Host register port
  input wire [`MSD_ADDR_W-1:0] address,
  input wire [`MSD_DATA_W-1:0] write_data,
  input wire write_strobe,
  input wire read_strobe,
  output reg [`MSD_DATA_W-1:0] read_data,
  // Signal processing side
  input wire baud_tick,
  input wire [`MSD_MODE_W-1:0] connection_mode,
  input wire [`MSD_DATA_W-1:0] line_energy,
  input wire [`MSD_DATA_W-1:0] eye_quality_level,
  input wire retrain_done,
  // Status and pins
  output reg retrain_start,
  output reg retrain_active,
  output reg carrier_detect_flag,
  output reg eye_quality_error,
  output reg hook_relay_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Mode classification

  // Data mode codes
  function is_data_mode;
    input [`MSD_MODE_W-1:0] mode;
    begin
      is_data_mode = (mode == `MSD_MODE_V22BIS) ||
        (mode == `MSD_MODE_V22) || (mode == `MSD_MODE_LEGACY_1200) ||
        (mode == `MSD_MODE_V21) || (mode == `MSD_MODE_LEGACY_300) ||
        (mode == `MSD_MODE_V23A) || (mode == `MSD_MODE_V23B);
    end
  endfunction

  // Modes in which the eye monitor is meaningful
  function is_eye_mode;
    input [`MSD_MODE_W-1:0] mode;
    begin
      is_eye_mode = (mode == `MSD_MODE_V22BIS) ||
        (mode == `MSD_MODE_V22) || (mode == `MSD_MODE_LEGACY_1200);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  reg force_retrain;
  reg hook_relay_enable;
  reg [`MSD_MODE_W-1:0] link_mode_select;
  wire wr_ctrl;
  wire wr_mode;
  wire wr_status;
  wire wr_on;
  wire wr_off;
  wire wr_eye;
  wire mode_is_data;
  wire mode_is_dial;
  wire start_now;

  assign wr_ctrl = write_strobe && (address == `MSD_ADDR_CTRL);
  assign wr_mode = write_strobe && (address == `MSD_ADDR_MODE);
  assign wr_status = write_strobe && (address == `MSD_ADDR_STATUS);
  assign wr_on = write_strobe && (address == `MSD_ADDR_ON_LEVEL);
  assign wr_off = write_strobe && (address == `MSD_ADDR_OFF_LEVEL);
  assign wr_eye = write_strobe && (address == `MSD_ADDR_EYE_LIMIT);
  assign mode_is_data = is_data_mode(write_data[`MSD_MODE_W-1:0]);
  assign mode_is_dial = (write_data[`MSD_MODE_W-1:0] == `MSD_MODE_DIAL);

  assign start_now = baud_tick && force_retrain && !retrain_active &&
    (connection_mode == `MSD_MODE_V22BIS);

  ////////////////////////////////////////////////////////////////////////////
  // Threshold words

  wire [`MSD_DATA_W-1:0] on_host;
  wire [`MSD_DATA_W-1:0] on_level;
  wire [`MSD_DATA_W-1:0] off_host;
  wire [`MSD_DATA_W-1:0] off_level;
  wire [`MSD_DATA_W-1:0] eye_host;
  wire [`MSD_DATA_W-1:0] eye_limit;

  msd_baud_word #(
    .WIDTH(`MSD_DATA_W),
    .RESET_VALUE(`MSD_ON_LEVEL_RESET)
  ) u_on_level (
    .clock(clock),
    .reset(reset),
    .write_en(wr_on),
    .write_data(write_data),
    .baud_tick(baud_tick),
    .host_value(on_host),
    .active_value(on_level)
  );

  msd_baud_word #(
    .WIDTH(`MSD_DATA_W),
    .RESET_VALUE(`MSD_OFF_LEVEL_RESET)
  ) u_off_level (
    .clock(clock),
    .reset(reset),
    .write_en(wr_off),
    .write_data(write_data),
    .baud_tick(baud_tick),
    .host_value(off_host),
    .active_value(off_level)
  );

  msd_baud_word #(
    .WIDTH(`MSD_DATA_W),
    .RESET_VALUE(`MSD_EYE_LIMIT_RESET)
  ) u_eye_limit (
    .clock(clock),
    .reset(reset),
    .write_en(wr_eye),
    .write_data(write_data),
    .baud_tick(baud_tick),
    .host_value(eye_host),
    .active_value(eye_limit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control word and mode

  always @(posedge clock) begin
    if (reset) begin
      force_retrain <= 1'b0;
      hook_relay_enable <= 1'b0;
      link_mode_select <= `MSD_MODE_IDLE;
    end else begin
      if (start_now) begin
        force_retrain <= 1'b0;
      end
      if (wr_mode) begin
        link_mode_select <= write_data[`MSD_MODE_W-1:0];
        if (mode_is_data) begin
          force_retrain <= 1'b0;
        end
        if (mode_is_data || mode_is_dial) begin
          hook_relay_enable <= 1'b1;
        end
      end
      // Host write wins over the device clear in the same cycle
      if (wr_ctrl) begin
        force_retrain <= write_data[`MSD_BIT_RETRAIN];
        hook_relay_enable <= write_data[`MSD_BIT_HOOK];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Retrain, carrier detect and eye quality

  always @(posedge clock) begin
    if (reset) begin
      retrain_start <= 1'b0;
      retrain_active <= 1'b0;
      carrier_detect_flag <= 1'b0;
      eye_quality_error <= 1'b0;
      hook_relay_n <= 1'b1;
    end else begin
      hook_relay_n <= ~hook_relay_enable;
      retrain_start <= start_now;
      if (start_now) begin
        retrain_active <= 1'b1;
        carrier_detect_flag <= 1'b0;
      end else if (retrain_active) begin
        if (retrain_done) begin
          retrain_active <= 1'b0;
          carrier_detect_flag <= 1'b1;
        end
      end else if (baud_tick) begin
        if (carrier_detect_flag && (line_energy < off_level)) begin
          carrier_detect_flag <= 1'b0;
        end else if (line_energy > on_level) begin
          carrier_detect_flag <= 1'b1;
        end
      end
      // Host write of one clears the error; a new event wins
      if (wr_status && write_data[`MSD_BIT_EQE]) begin
        eye_quality_error <= 1'b0;
      end
      if (baud_tick && is_eye_mode(connection_mode) &&
          (eye_quality_level > eye_limit)) begin
        eye_quality_error <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read back

  reg [`MSD_DATA_W-1:0] next_read_data;

  always @* begin
    next_read_data = {`MSD_DATA_W{1'b0}};
    if (address == `MSD_ADDR_CTRL) begin
      next_read_data[`MSD_BIT_RETRAIN] = force_retrain;
      next_read_data[`MSD_BIT_HOOK] = hook_relay_enable;
    end else if (address == `MSD_ADDR_MODE) begin
      next_read_data[`MSD_MODE_W-1:0] = link_mode_select;
    end else if (address == `MSD_ADDR_STATUS) begin
      next_read_data[`MSD_BIT_CARRIER_DETECT_FLAG] = carrier_detect_flag;
      next_read_data[`MSD_BIT_EQE] = eye_quality_error;
    end else if (address == `MSD_ADDR_ON_LEVEL) begin
      next_read_data = on_host;
    end else if (address == `MSD_ADDR_OFF_LEVEL) begin
      next_read_data = off_host;
    end else if (address == `MSD_ADDR_EYE_LIMIT) begin
      next_read_data = eye_host;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      read_data <= {`MSD_DATA_W{1'b0}};
    end else if (read_strobe) begin
      read_data <= next_read_data;
    end else begin
      read_data <= {`MSD_DATA_W{1'b0}};
    end
  end

endmodule

/* design/msd_defines.vh */
// Offsets, field positions, reset values and mode codes of the status block
`ifndef MSD_DEFINES_VH
`define MSD_DEFINES_VH
`define MSD_ADDR_W 9
`define MSD_DATA_W 16
`define MSD_ADDR_CTRL 9'h01f
`define MSD_ADDR_ON_LEVEL 9'h1f4
`define MSD_ADDR_OFF_LEVEL 9'h1f5
`define MSD_ADDR_EYE_LIMIT 9'h1f6
`define MSD_ADDR_MODE 9'h1e0
`define MSD_ADDR_STATUS 9'h1e1
`define MSD_BIT_RETRAIN 11
`define MSD_BIT_HOOK 10
`define MSD_BIT_CARRIER_DETECT_FLAG 1
`define MSD_BIT_EQE 4
`define MSD_CTRL_RESET 16'h0000
`define MSD_EYE_LIMIT_RESET 16'h0400
`define MSD_ON_LEVEL_RESET 16'h00e8
`define MSD_OFF_LEVEL_RESET 16'h0082
`define MSD_MODE_W 7
`define MSD_MODE_IDLE 7'h00
`define MSD_MODE_DIAL 7'h03
`define MSD_MODE_V22BIS 7'h08
`define MSD_MODE_V22 7'h09
`define MSD_MODE_LEGACY_1200 7'h0b
`define MSD_MODE_V21 7'h10
`define MSD_MODE_LEGACY_300 7'h11
`define MSD_MODE_V23A 7'h13
`define MSD_MODE_V23B 7'h14
`endif

/* design/msd_baud_word.v */
// Host-written word that takes effect only at the next baud boundary
`timescale 1ns/100ps
module msd_baud_word #(
  parameter WIDTH = 16,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  // Clock and reset
  input wire clock,
  input wire reset,
  // Host side
  input wire write_en,
  input wire [WIDTH-1:0] write_data,
  // Baud pacing
  input wire baud_tick,
  // Values
  output reg [WIDTH-1:0] host_value,
  output reg [WIDTH-1:0] active_value
);

  always @(posedge clock) begin
    if (reset) begin
      host_value <= RESET_VALUE;
      active_value <= RESET_VALUE;
    end else begin
      if (write_en) begin
        host_value <= write_data;
      end
      if (baud_tick) begin
        active_value <= host_value;
      end
    end
  end

endmodule

/* testbench/msd_status_sva.sv */
// Assertions on the status block ports
`timescale 1ns/100ps
`include "msd_defines.vh"
module msd_status_sva (
  // Clock and reset
  input wire clock,
  input wire reset,
  // Host port
  input wire [`MSD_ADDR_W-1:0] address,
  input wire [`MSD_DATA_W-1:0] write_data,
  input wire write_strobe,
  // Signal processing side
  input wire baud_tick,
  input wire [`MSD_MODE_W-1:0] connection_mode,
  input wire retrain_done,
  // Status and pins
  input wire retrain_start,
  input wire retrain_active,
  input wire carrier_detect_flag,
  input wire eye_quality_error,
  input wire hook_relay_n
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  AST_RESET_HOOK: assert property ($fell(reset) |-> hook_relay_n)
    else $error("relay pin active after reset");
  AST_DIAL_HOOK: assert property (write_strobe &&
    address == `MSD_ADDR_MODE && write_data[6:0] == `MSD_MODE_DIAL
    |-> ##2 !hook_relay_n) else $error("dial write left relay open");
  AST_DATA_HOOK: assert property (write_strobe &&
    address == `MSD_ADDR_MODE && write_data[6:0] inside {7'h08, 7'h09,
    7'h0b, 7'h10, 7'h11, 7'h13, 7'h14} |-> ##2 !hook_relay_n)
    else $error("data mode write left relay open");
  AST_RT_START: assert property (retrain_start |-> $past(baud_tick) &&
    $past(connection_mode) == `MSD_MODE_V22BIS)
    else $error("retrain started without cause");
  AST_RT_PULSE: assert property (retrain_start |=> !retrain_start)
    else $error("retrain start pulse held");
  AST_RT_CARRIER_DETECT_FLAG: assert property (retrain_start |->
    !carrier_detect_flag && retrain_active)
    else $error("carrier flag kept at retrain start");
  AST_RT_DONE: assert property (retrain_active && retrain_done
    |=> carrier_detect_flag && !retrain_active)
    else $error("carrier flag not restored after retrain");
  AST_CARRIER_DETECT_FLAG_RISE: assert property ($rose(carrier_detect_flag) |->
    $past(baud_tick) || $past(retrain_done))
    else $error("carrier flag rose off a baud boundary");
  AST_CARRIER_DETECT_FLAG_FALL: assert property ($fell(carrier_detect_flag)
    |-> $past(baud_tick)) else $error("carrier flag fell off a boundary");
  AST_EYE: assert property ($rose(eye_quality_error) |->
    $past(baud_tick) && $past(connection_mode) inside {7'h08, 7'h09, 7'h0b})
    else $error("eye error set outside a qualifying tick");
endmodule
bind msd_status msd_status_sva i_msd_status_sva (.clock, .reset,
  .address, .write_data, .write_strobe, .baud_tick, .connection_mode,
  .retrain_done, .retrain_start, .retrain_active, .carrier_detect_flag,
  .eye_quality_error, .hook_relay_n);

/* testbench/msd_host_model.sv */
// Host processor model driving the register port
`timescale 1ns/100ps
module msd_host_model (
  // Clock
  input wire clock,
  // Register port
  output logic [8:0] address,
  output logic [15:0] write_data,
  output logic write_strobe,
  output logic read_strobe,
  input wire [15:0] read_data
);
  initial begin
    address = 9'h000;
    write_data = 16'h0000;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
  end
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
    // Released lines no longer show the last value
    address <= ~a;
    write_data <= ~d;
  endtask
  task automatic rd(input logic [8:0] a, output logic [15:0] d);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    address <= ~a;
    #1 d = read_data;
  endtask
endmodule

/* testbench/msd_status_tb.sv */
// Self-checking bench of the status block
`timescale 1ns/100ps
`include "msd_defines.vh"
module msd_status_tb;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic baud_tick = 1'b0;
  logic retrain_done = 1'b0;
  logic [6:0] connection_mode = 7'h00;
  logic [15:0] line_energy = 16'h0000;
  logic [15:0] eye_quality_level = 16'h0000;
  wire [8:0] address;
  wire [15:0] write_data;
  wire [15:0] read_data;
  wire write_strobe;
  wire read_strobe;
  wire retrain_start;
  wire retrain_active;
  wire carrier_detect_flag;
  wire eye_quality_error;
  wire hook_relay_n;
  int errors = 0;
  int checks = 0;
  logic [15:0] d;
  initial forever #2.5 clock = ~clock;
  msd_host_model i_msd_host_model (.clock, .address, .write_data,
    .write_strobe, .read_strobe, .read_data);
  msd_status i_msd_status (.clock, .reset, .address, .write_data,
    .write_strobe, .read_strobe, .read_data, .baud_tick, .connection_mode,
    .line_energy, .eye_quality_level, .retrain_done, .retrain_start,
    .retrain_active, .carrier_detect_flag, .eye_quality_error, .hook_relay_n);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input logic [8:0] a, input logic [15:0] v);
    i_msd_host_model.wr(a, v);
  endtask
  task automatic rd(input logic [8:0] a);
    i_msd_host_model.rd(a, d);
  endtask
  task automatic tick(input logic [15:0] e, input logic [15:0] q);
    @(posedge clock);
    baud_tick <= 1'b1;
    line_energy <= e;
    eye_quality_level <= q;
    @(posedge clock);
    baud_tick <= 1'b0;
    #1;
  endtask
  task automatic t_reset;
    logic [8:0] a [0:6];
    logic [15:0] v [0:6];
    a = '{`MSD_ADDR_CTRL, `MSD_ADDR_MODE, `MSD_ADDR_STATUS, `MSD_ADDR_ON_LEVEL,
      `MSD_ADDR_OFF_LEVEL, `MSD_ADDR_EYE_LIMIT, 9'h100};
    v = '{16'h0000, 16'h0000, 16'h0000, 16'h00e8, 16'h0082, 16'h0400, 16'h0000};
    for (int i = 0; i < 7; i++) begin
      rd(a[i]);
      chk(d, v[i]);
    end
    chk({15'h0000, hook_relay_n}, 16'h0001);
  endtask
  task automatic t_hook_modes;
    logic [6:0] m [0:7];
    m = '{`MSD_MODE_V22BIS, `MSD_MODE_V22, `MSD_MODE_LEGACY_1200,
      `MSD_MODE_V21, `MSD_MODE_LEGACY_300, `MSD_MODE_V23A, `MSD_MODE_V23B,
      `MSD_MODE_DIAL};
    wr(`MSD_ADDR_CTRL, 16'h0400);
    @(posedge clock);
    #1 chk({15'h0000, hook_relay_n}, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      // relay bit only written while idle
      wr(`MSD_ADDR_MODE, 16'h0000);
      wr(`MSD_ADDR_CTRL, 16'h0800);
      @(posedge clock);
      #1 chk({15'h0000, hook_relay_n}, 16'h0001);
      wr(`MSD_ADDR_MODE, {9'h000, m[i]});
      rd(`MSD_ADDR_CTRL);
      chk(d, (i == 7) ? 16'h0c00 : 16'h0400);
    end
  endtask
  task automatic t_carrier;
    wr(`MSD_ADDR_ON_LEVEL, 16'h0100);
    wr(`MSD_ADDR_OFF_LEVEL, 16'h0080);
    tick(16'h00f0, 16'h0000);
    chk({15'h0000, carrier_detect_flag}, 16'h0001);
    tick(16'h0081, 16'h0000);
    chk({15'h0000, carrier_detect_flag}, 16'h0001);
    tick(16'h007f, 16'h0000);
    chk({15'h0000, carrier_detect_flag}, 16'h0000);
    tick(16'h00ff, 16'h0000);
    chk({15'h0000, carrier_detect_flag}, 16'h0000);
    tick(16'h0101, 16'h0000);
    chk({15'h0000, carrier_detect_flag}, 16'h0001);
    @(posedge clock);
    line_energy <= 16'h0000;
    repeat (3) @(posedge clock);
    #1 chk({15'h0000, carrier_detect_flag}, 16'h0001);
  endtask
  task automatic t_eye_retrain;
    @(posedge clock);
    connection_mode <= `MSD_MODE_V22;
    wr(`MSD_ADDR_EYE_LIMIT, 16'h0010);
    tick(16'h0101, 16'h0011);
    chk({15'h0000, eye_quality_error}, 16'h0000);
    tick(16'h0101, 16'h0010);
    chk({15'h0000, eye_quality_error}, 16'h0000);
    tick(16'h0101, 16'h0011);
    rd(`MSD_ADDR_STATUS);
    chk(d & 16'h0012, 16'h0012);
    wr(`MSD_ADDR_STATUS, 16'h0010);
    wr(`MSD_ADDR_MODE, 16'h0000);
    wr(`MSD_ADDR_CTRL, 16'h0800);
    tick(16'h0101, 16'hffff);
    chk({15'h0000, eye_quality_error}, 16'h0001);
    chk({15'h0000, retrain_active}, 16'h0000);
    @(posedge clock);
    connection_mode <= `MSD_MODE_V21;
    wr(`MSD_ADDR_STATUS, 16'h0010);
    tick(16'h0101, 16'hffff);
    chk({15'h0000, eye_quality_error}, 16'h0000);
    @(posedge clock);
    connection_mode <= `MSD_MODE_LEGACY_1200;
    tick(16'h0101, 16'hffff);
    chk({15'h0000, eye_quality_error}, 16'h0001);
    @(posedge clock);
    connection_mode <= `MSD_MODE_V22BIS;
    tick(16'h0101, 16'h0000);
    chk({13'h0000, retrain_start, retrain_active, carrier_detect_flag},
      16'h0006);
    rd(`MSD_ADDR_CTRL);
    chk(d, 16'h0000);
    tick(16'h0101, 16'h0000);
    chk({15'h0000, carrier_detect_flag}, 16'h0000);
    @(posedge clock);
    retrain_done <= 1'b1;
    @(posedge clock);
    retrain_done <= 1'b0;
    #1 chk({14'h0000, retrain_active, carrier_detect_flag}, 16'h0001);
  endtask
  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    t_reset;
    t_hook_modes;
    // Second reset with the relay closed and the force bit set
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    t_reset;
    t_carrier;
    t_eye_retrain;
    test_done;
  end
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    test_done;
  end
endmodule
